// ===== verilog/cae_exec.sv
// Decode and execute of three add instructions over four quarter-phases,
// with the accumulator, status, bank select and file pointers as registers.
// Assumes data memory reads combinationally from mem_addr within one clock.
//
// Functional notes
// RULE1: Literal add sums immediate into accumulator
// RULE2: Literal add opcode upper byte 0000 1111
// RULE3: File add top six bits 001001
// RULE4: File add destination bit selects target
// RULE5: Access bit picks access or selected bank
// RULE6: Extended mode indexes low offsets via pointer
// RULE7: Accumulator adds update five status flags
// RULE8: Literal add spans Q1 to Q4
// RULE9: Pointer add writes pointer in Q4
// RULE10: Pointer add six-bit immediate, flags untouched
// RULE11: Flags: carry, half carry, overflow, sign, zero
`timescale 1ns/1ps
module cae_exec
  import cae_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_take,
  output logic [CAE_ADDR_W-1:0] mem_addr,
  input wire logic [CAE_DATA_W-1:0] mem_rdata,
  output logic [CAE_DATA_W-1:0] mem_wdata,
  output logic mem_we,
  input wire logic [CAE_RADDR_W-1:0] reg_addr,
  input wire logic [CAE_BUS_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [CAE_BUS_W-1:0] reg_rdata,
  output logic [CAE_DATA_W-1:0] accumulator,
  output logic [CAE_FLAG_W-1:0] status_flags
);

  cae_phase_t phase_q;
  cae_phase_t phase_d;
  cae_op_t op_q;
  logic [15:0] instr_q;
  logic [CAE_DATA_W-1:0] operand_q;
  logic [CAE_DATA_W-1:0] result_q;
  logic [CAE_FLAG_W-1:0] result_flags_q;
  logic [CAE_PTR_W-1:0] ptr_sum_q;
  logic [CAE_DATA_W-1:0] acc_q;
  logic [CAE_FLAG_W-1:0] status_q;
  logic [CAE_BANK_W-1:0] bank_q;
  logic ext_en_q;
  logic [CAE_PTR_W-1:0] ptr_q [CAE_PTR_COUNT];
  logic [CAE_ADDR_W-1:0] mem_addr_q;
  logic [CAE_DATA_W-1:0] mem_wdata_q;
  logic mem_we_q;
  logic [CAE_BUS_W-1:0] reg_rdata_q;
  cae_op_t dec_op;
  logic [CAE_DATA_W-1:0] alu_sum;
  logic [CAE_FLAG_W-1:0] alu_flags;
  logic [CAE_ADDR_W-1:0] file_addr;
  logic file_indexed;
  logic [1:0] ptr_sel;

  // Instruction classification from the raw word
  function automatic cae_op_t decode_op(input logic [15:0] word);
    if (word[15:8] == CAE_OPC_ADD_LIT) begin
      decode_op = CAE_OP_ADD_LIT; // [RULE2]
    end else if (word[15:10] == CAE_OPC_ADD_FILE) begin
      decode_op = CAE_OP_ADD_FILE; // [RULE3]
    end else if (word[15:8] == CAE_OPC_ADD_PTR && word[7:6] != 2'h3) begin
      decode_op = CAE_OP_ADD_PTR;
    end else begin
      decode_op = CAE_OP_NONE;
    end
  endfunction

  // Register read mux, used only for the bus read path
  function automatic logic [CAE_BUS_W-1:0] read_mux(input logic [CAE_RADDR_W-1:0] addr);
    case (addr)
      CAE_REG_ACC: read_mux = {8'h00, acc_q};
      CAE_REG_STATUS: read_mux = {11'h000, status_q};
      CAE_REG_BANK: read_mux = {10'h000, bank_q};
      CAE_REG_CTRL: read_mux = {15'h0000, ext_en_q};
      CAE_REG_PTR0: read_mux = {2'h0, ptr_q[0]};
      CAE_REG_PTR1: read_mux = {2'h0, ptr_q[1]};
      CAE_REG_PTR2: read_mux = {2'h0, ptr_q[2]};
      default: read_mux = 16'h0000;
    endcase
  endfunction

  assign dec_op = decode_op(instr_word);
  assign instr_take = (phase_q == CAE_Q1);
  assign ptr_sel = instr_q[CAE_PTR_SEL_LSB +: 2];
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_we = mem_we_q;
  assign reg_rdata = reg_rdata_q;
  assign accumulator = acc_q;
  assign status_flags = status_q;

  cae_alu u_alu (
    .op_a(acc_q),
    .op_b(operand_q),
    .sum(alu_sum),
    .flags(alu_flags)
  );

  cae_addr u_addr (
    .file_addr(instr_word[7:0]),
    .access_sel(instr_word[CAE_ACCESS_BIT]),
    .extended_en(ext_en_q),
    .bank_select(bank_q),
    .index_ptr(ptr_q[CAE_INDEX_PTR]),
    .data_addr(file_addr),
    .indexed(file_indexed)
  );

  // Quarter-phase sequencer: one instruction cycle is four clocks
  always_comb begin
    case (phase_q)
      CAE_Q1: phase_d = CAE_Q2;
      CAE_Q2: phase_d = CAE_Q3;
      CAE_Q3: phase_d = CAE_Q4;
      CAE_Q4: phase_d = CAE_Q1;
      default: phase_d = CAE_Q1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_q <= CAE_Q1;
    end else begin
      phase_q <= phase_d; // [RULE8] [RULE9]
    end
  end

  // Q1: decode and present the operand address
  always_ff @(posedge clock) begin
    if (rst) begin
      op_q <= CAE_OP_NONE;
      instr_q <= CAE_INSTR_RST;
      mem_addr_q <= '0;
    end else if (phase_q == CAE_Q1) begin
      op_q <= instr_valid ? dec_op : CAE_OP_NONE; // [RULE8] [RULE9]
      instr_q <= instr_word;
      if (instr_valid && dec_op == CAE_OP_ADD_FILE) begin
        mem_addr_q <= file_addr; // [RULE5] [RULE6]
      end
    end
  end

  // Q2: fetch the immediate or the file register
  always_ff @(posedge clock) begin
    if (rst) begin
      operand_q <= '0;
    end else if (phase_q == CAE_Q2) begin
      case (op_q)
        CAE_OP_ADD_LIT: operand_q <= instr_q[7:0]; // [RULE1]
        CAE_OP_ADD_FILE: operand_q <= mem_rdata; // [RULE4]
        CAE_OP_ADD_PTR: operand_q <= {2'h0, instr_q[CAE_PTR_LIT_W-1:0]}; // [RULE10]
        default: operand_q <= operand_q;
      endcase
    end
  end

  // Q3: compute; file write-back is staged for the Q4 clock
  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= '0;
      result_flags_q <= '0;
      ptr_sum_q <= '0;
    end else if (phase_q == CAE_Q3) begin
      result_q <= alu_sum;
      result_flags_q <= alu_flags; // [RULE7]
      if (op_q == CAE_OP_ADD_PTR && ptr_sel != 2'h3) begin
        // Unsigned immediate, no flags involved
        ptr_sum_q <= CAE_PTR_W'(ptr_q[ptr_sel] + {8'h00, operand_q[CAE_PTR_LIT_W-1:0]}); // [RULE10]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= '0;
    end else if (phase_q == CAE_Q3) begin
      mem_we_q <= (op_q == CAE_OP_ADD_FILE) && instr_q[CAE_DEST_BIT]; // [RULE4]
      mem_wdata_q <= alu_sum;
    end else begin
      mem_we_q <= 1'b0;
    end
  end

  // Accumulator: Q4 write-back wins over a bus write in the same clock
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= CAE_ACC_RST;
    end else if (phase_q == CAE_Q4 && op_q == CAE_OP_ADD_LIT) begin
      acc_q <= result_q; // [RULE1] [RULE8]
    end else if (phase_q == CAE_Q4 && op_q == CAE_OP_ADD_FILE && !instr_q[CAE_DEST_BIT]) begin
      acc_q <= result_q; // [RULE4]
    end else if (reg_write && reg_addr == CAE_REG_ACC) begin
      acc_q <= reg_wdata[CAE_DATA_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= CAE_STATUS_RST;
    end else if (phase_q == CAE_Q4 &&
                 (op_q == CAE_OP_ADD_LIT || op_q == CAE_OP_ADD_FILE)) begin
      status_q <= result_flags_q; // [RULE7]
    end else if (reg_write && reg_addr == CAE_REG_STATUS) begin
      status_q <= reg_wdata[CAE_FLAG_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bank_q <= CAE_BANK_RST;
      ext_en_q <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == CAE_REG_BANK) begin
        bank_q <= reg_wdata[CAE_BANK_W-1:0];
      end
      if (reg_addr == CAE_REG_CTRL) begin
        ext_en_q <= reg_wdata[CAE_CTRL_EXT_BIT];
      end
    end
  end

  // File pointers, one register per index
  for (genvar gi = 0; gi < CAE_PTR_COUNT; gi++) begin : g_ptr
    always_ff @(posedge clock) begin
      if (rst) begin
        ptr_q[gi] <= CAE_PTR_RST;
      end else if (phase_q == CAE_Q4 && op_q == CAE_OP_ADD_PTR && ptr_sel == 2'(gi)) begin
        ptr_q[gi] <= ptr_sum_q; // [RULE9] [RULE10]
      end else if (reg_write && reg_addr == CAE_REG_PTR0 + 8'(4 * gi)) begin
        ptr_q[gi] <= reg_wdata[CAE_PTR_W-1:0];
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (reg_read) begin
      reg_rdata_q <= read_mux(reg_addr);
    end else begin
      reg_rdata_q <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  lit_decode_a: assert property ( // [RULE2]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:8] == 8'h0F) |=> op_q == CAE_OP_ADD_LIT)
    else $error("literal add not decoded");

  file_decode_a: assert property ( // [RULE3]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:10] == 6'h09) |=> op_q == CAE_OP_ADD_FILE)
    else $error("file add not decoded");

  lit_acc_sum_a: assert property ( // [RULE1]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:8] == 8'h0F && !reg_write)
      ##1 (!reg_write) [*3]
      |=> acc_q == 8'($past(acc_q, 4) + $past(instr_word[7:0], 4)))
    else $error("literal add result wrong");

  lit_q4_timing_a: assert property ( // [RULE8]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:8] == 8'h0F && !reg_write)
      ##1 (!reg_write) [*2] |=> $stable(acc_q))
    else $error("accumulator written before Q4");

  file_dest_a: assert property ( // [RULE4]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:10] == 6'h09)
      |-> ##3 (mem_we_q == instr_q[CAE_DEST_BIT] && phase_q == CAE_Q4))
    else $error("file write-back enable wrong");

  access_bank_a: assert property ( // [RULE5]
    (phase_q == CAE_Q1 && instr_valid && dec_op == CAE_OP_ADD_FILE
      && !instr_word[CAE_ACCESS_BIT] && !ext_en_q && instr_word[7:0] < 8'h60)
      |=> mem_addr_q == {6'h00, $past(instr_word[7:0])})
    else $error("access bank address wrong");

  indexed_addr_a: assert property ( // [RULE6]
    (phase_q == CAE_Q1 && instr_valid && dec_op == CAE_OP_ADD_FILE
      && !instr_word[CAE_ACCESS_BIT] && ext_en_q && instr_word[7:0] <= 8'h5F)
      |=> mem_addr_q == 14'($past(ptr_q[2]) + $past(instr_word[7:0])))
    else $error("indexed address wrong");

  flag_result_a: assert property ( // [RULE7] [RULE11]
    (phase_q == CAE_Q4 && op_q == CAE_OP_ADD_LIT)
      |=> status_q[CAE_FLAG_Z] == (acc_q == 8'h00) && status_q[CAE_FLAG_N] == acc_q[7])
    else $error("zero or negative flag disagrees with result");

  ptr_add_a: assert property ( // [RULE9] [RULE10]
    (phase_q == CAE_Q1 && instr_valid && instr_word[15:6] == {8'hE8, 2'h1} && !reg_write)
      ##1 (!reg_write) [*3]
      |=> ptr_q[1] == 14'($past(ptr_q[1], 4) + $past(instr_word[5:0], 4))
          && status_q == $past(status_q, 4))
    else $error("pointer add wrong or flags disturbed");

endmodule

// ===== verilog/cae_pkg.sv
// Constants, encodings and register map for the add-instruction execute block.
// Assumes a single 200 MHz core clock; one instruction cycle is four quarter-phases.
package cae_pkg;

  localparam int unsigned CAE_DATA_W = 8;
  localparam int unsigned CAE_ADDR_W = 14;
  localparam int unsigned CAE_PTR_W = 14;
  localparam int unsigned CAE_BANK_W = 6;
  localparam int unsigned CAE_PTR_COUNT = 3;
  localparam int unsigned CAE_FLAG_W = 5;
  localparam int unsigned CAE_BUS_W = 16;
  localparam int unsigned CAE_RADDR_W = 8;

  // Quarter-phases of one instruction cycle
  typedef enum logic [1:0] {
    CAE_Q1 = 2'b00,
    CAE_Q2 = 2'b01,
    CAE_Q3 = 2'b10,
    CAE_Q4 = 2'b11
  } cae_phase_t;

  typedef enum logic [1:0] {
    CAE_OP_NONE = 2'b00,
    CAE_OP_ADD_LIT = 2'b01,
    CAE_OP_ADD_FILE = 2'b10,
    CAE_OP_ADD_PTR = 2'b11
  } cae_op_t;

  // Opcode fields of the 16-bit instruction word
  localparam logic [7:0] CAE_OPC_ADD_LIT = 8'h0F;
  localparam logic [5:0] CAE_OPC_ADD_FILE = 6'h09;
  localparam logic [7:0] CAE_OPC_ADD_PTR = 8'hE8;
  localparam int unsigned CAE_DEST_BIT = 9;
  localparam int unsigned CAE_ACCESS_BIT = 8;
  localparam int unsigned CAE_PTR_SEL_LSB = 6;
  localparam int unsigned CAE_PTR_LIT_W = 6;

  // Data memory addressing
  localparam logic [7:0] CAE_INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] CAE_ACCESS_SPLIT = 8'h60;
  localparam logic [CAE_BANK_W-1:0] CAE_ACCESS_LOW_BANK = 6'h00;
  localparam logic [CAE_BANK_W-1:0] CAE_ACCESS_HIGH_BANK = 6'h3F;
  localparam logic [1:0] CAE_INDEX_PTR = 2'h2;

  // Status flag positions
  localparam int unsigned CAE_FLAG_C = 0;
  localparam int unsigned CAE_FLAG_DIGIT_CARRY = 1;
  localparam int unsigned CAE_FLAG_Z = 2;
  localparam int unsigned CAE_FLAG_OVERFLOW = 3;
  localparam int unsigned CAE_FLAG_N = 4;

  // Register map, byte addresses
  localparam logic [7:0] CAE_REG_ACC = 8'h00;
  localparam logic [7:0] CAE_REG_STATUS = 8'h04;
  localparam logic [7:0] CAE_REG_BANK = 8'h08;
  localparam logic [7:0] CAE_REG_CTRL = 8'h0C;
  localparam logic [7:0] CAE_REG_PTR0 = 8'h10;
  localparam logic [7:0] CAE_REG_PTR1 = 8'h14;
  localparam logic [7:0] CAE_REG_PTR2 = 8'h18;
  localparam int unsigned CAE_CTRL_EXT_BIT = 0;

  // Reset values
  localparam logic [CAE_DATA_W-1:0] CAE_ACC_RST = 8'h00;
  localparam logic [CAE_FLAG_W-1:0] CAE_STATUS_RST = 5'h00;
  localparam logic [CAE_BANK_W-1:0] CAE_BANK_RST = 6'h00;
  localparam logic [CAE_PTR_W-1:0] CAE_PTR_RST = 14'h0000;
  localparam logic [15:0] CAE_INSTR_RST = 16'h0000;

endpackage

// ===== verilog/cae_alu.sv
// Eight-bit adder with arithmetic status flags.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module cae_alu
  import cae_pkg::*;
(
  input wire logic [CAE_DATA_W-1:0] op_a,
  input wire logic [CAE_DATA_W-1:0] op_b,
  output logic [CAE_DATA_W-1:0] sum,
  output logic [CAE_FLAG_W-1:0] flags
);

  logic [CAE_DATA_W:0] full_sum;
  logic [4:0] low_sum;

  always_comb begin
    full_sum = {1'b0, op_a} + {1'b0, op_b};
    low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    sum = full_sum[CAE_DATA_W-1:0];
    flags = '0;
    flags[CAE_FLAG_C] = full_sum[CAE_DATA_W]; // [RULE11]
    flags[CAE_FLAG_DIGIT_CARRY] = low_sum[4]; // [RULE11]
    // Signed overflow: like-signed operands giving a differently signed sum
    flags[CAE_FLAG_OVERFLOW] = (op_a[7] == op_b[7]) && (full_sum[7] != op_a[7]); // [RULE11]
    flags[CAE_FLAG_N] = full_sum[7]; // [RULE11]
    flags[CAE_FLAG_Z] = (full_sum[CAE_DATA_W-1:0] == 8'h00); // [RULE11]
  end

endmodule

// ===== verilog/cae_addr.sv
// Data memory address former for file-register operands.
// Combinational; inputs come from the instruction word and core registers.
`timescale 1ns/1ps
module cae_addr
  import cae_pkg::*;
(
  input wire logic [7:0] file_addr,
  input wire logic access_sel,
  input wire logic extended_en,
  input wire logic [CAE_BANK_W-1:0] bank_select,
  input wire logic [CAE_PTR_W-1:0] index_ptr,
  output logic [CAE_ADDR_W-1:0] data_addr,
  output logic indexed
);

  always_comb begin
    indexed = !access_sel && extended_en && (file_addr <= CAE_INDEXED_LIMIT); // [RULE6]
    if (access_sel) begin
      data_addr = {bank_select, file_addr}; // [RULE5]
    end else if (indexed) begin
      // Offset is added to the index pointer, wrapping within the pointer width
      data_addr = CAE_ADDR_W'(index_ptr + {6'h00, file_addr}); // [RULE6]
    end else if (file_addr < CAE_ACCESS_SPLIT) begin
      data_addr = {CAE_ACCESS_LOW_BANK, file_addr}; // [RULE5]
    end else begin
      data_addr = {CAE_ACCESS_HIGH_BANK, file_addr}; // [RULE5]
    end
  end

endmodule

// ===== bench/testbench.sv
// Self-checking bench for the add-instruction execute block.
// Assumes the block is the top; the bench models data memory and all other stimulus.
`timescale 1ns/1ps
module testbench;
  import cae_pkg::*;
  logic clock, rst, instr_valid, instr_take, mem_we, reg_write, reg_read;
  logic [15:0] instr_word;
  logic [CAE_ADDR_W-1:0] mem_addr;
  logic [CAE_DATA_W-1:0] mem_rdata, mem_wdata, accumulator;
  logic [CAE_RADDR_W-1:0] reg_addr;
  logic [CAE_BUS_W-1:0] reg_wdata, reg_rdata;
  logic [CAE_FLAG_W-1:0] status_flags;
  logic [7:0] mem [0:16383];
  logic [1:0] bph;
  integer seed, errors, n_checks, cycles;
  logic [7:0] m_acc;
  logic [4:0] m_st;
  logic [5:0] m_bank;
  logic m_ext;
  logic [13:0] m_ptr [0:2];
  logic [31:0] r;

  cae_exec cae_exec_i (.clock(clock), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_take(instr_take), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .accumulator(accumulator), .status_flags(status_flags));

  // Combinational data memory, written at the edge that ends the write cycle
  assign mem_rdata = mem[mem_addr];
  always @(posedge clock) if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
  // Bench copy of the quarter-phase; three means the cycle just ended was Q4
  always @(posedge clock) bph <= rst ? 2'h0 : bph + 2'h1;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles > 20000) begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [12:0] addf(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] f;
    s = {1'b0, a} + {1'b0, b};
    f[CAE_FLAG_C] = s[8];
    f[CAE_FLAG_DIGIT_CARRY] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    f[CAE_FLAG_Z] = s[7:0] == 8'h00;
    f[CAE_FLAG_OVERFLOW] = (a[7] == b[7]) && (s[7] != a[7]);
    f[CAE_FLAG_N] = s[7];
    return {f, s[7:0]};
  endfunction

  function automatic logic [13:0] exp_addr(input logic [7:0] f, input logic a);
    if (a) return {m_bank, f};
    if (m_ext && f <= 8'h5F) return m_ptr[2] + 14'(f);
    return {(f >= 8'h60) ? 6'h3F : 6'h00, f};
  endfunction

  // Bus tasks start and end on a rising edge; two edges each so no strobe is set twice
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk("reg read", reg_rdata, exp);
    @(posedge clock);
  endtask

  task automatic run(input logic [15:0] w);
    logic [7:0] op, sum;
    logic [4:0] fl;
    logic [13:0] ea;
    logic isl, isf, isp, d;
    isl = w[15:8] == 8'h0F;
    isf = w[15:10] == 6'b001001;
    isp = w[15:8] == 8'hE8 && w[7:6] != 2'h3;
    d = w[9];
    ea = exp_addr(w[7:0], w[8]);
    while (bph !== 2'h3) @(posedge clock);
    instr_word <= w;
    instr_valid <= 1'b1;
    #1 chk("take", 16'(instr_take), 16'h0001);
    @(posedge clock);
    // A stray literal add held valid through Q2 to Q4 must be ignored; valid drops before the next Q1
    instr_word <= {8'h0F, 8'($random(seed))};
    #1 if (isf) chk("addr", 16'(mem_addr), 16'(ea));
    chk("take off", 16'(instr_take), 16'h0000);
    op = isf ? mem[ea] : w[7:0];
    {fl, sum} = addf(m_acc, op);
    @(posedge clock);
    @(posedge clock);
    #1 chk("we", 16'(mem_we), 16'(isf && d));
    if (isf && d) chk("wdata", 16'(mem_wdata), 16'(sum));
    chk("acc early", 16'(accumulator), 16'(m_acc));
    if (isl || isf) m_st = fl;
    if (isl || (isf && !d)) m_acc = sum;
    if (isp) m_ptr[w[7:6]] = m_ptr[w[7:6]] + 14'(w[5:0]);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1 chk("acc", 16'(accumulator), 16'(m_acc));
    chk("flags", 16'(status_flags), 16'(m_st));
    chk("we off", 16'(mem_we), 16'h0000);
    @(posedge clock);
    if (isp) reg_rd(CAE_REG_PTR0 + 8'(w[7:6] * 4), 16'(m_ptr[w[7:6]]));
  endtask

  initial begin
    seed = 33;
    errors = 0;
    n_checks = 0;
    cycles = 0;
    rst = 1'b1;
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    m_acc = 8'h00;
    m_st = 5'h00;
    m_bank = 6'h00;
    m_ext = 1'b0;
    for (int i = 0; i < 3; i++) m_ptr[i] = 14'h0000;
    for (int i = 0; i < 16384; i++) mem[i] = 8'($random(seed));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Reset values, plus one unmapped address at 1C
    for (int i = 0; i < 8; i++) reg_rd(8'(i * 4), 16'h0000);
    run(16'h0F10);
    run(16'h0F15);
    reg_wr(CAE_REG_PTR2, 16'h03FF);
    m_ptr[2] = 14'h03FF;
    run(16'hE8A3);
    // Flag corners: wrap to zero, signed overflow
    reg_wr(CAE_REG_ACC, 16'h00FF);
    m_acc = 8'hFF;
    run(16'h0F01);
    reg_wr(CAE_REG_ACC, 16'h007F);
    m_acc = 8'h7F;
    run(16'h0F01);
    reg_rd(CAE_REG_STATUS, 16'(m_st));
    // Indexed boundary at 5F and 60, extended mode off then on, then banked access
    reg_wr(CAE_REG_BANK, 16'h0015);
    m_bank = 6'h15;
    reg_rd(CAE_REG_BANK, 16'h0015);
    for (int e = 0; e < 2; e++) begin
      reg_wr(CAE_REG_CTRL, 16'(e));
      m_ext = e[0];
      reg_rd(CAE_REG_CTRL, 16'(e));
      run(16'h265F);
      run(16'h2460);
      run(16'h255F);
    end
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      reg_wr(CAE_REG_PTR0 + 8'(i * 4), 16'(r[13:0]));
      m_ptr[i] = r[13:0];
    end
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: run({8'h0F, r[15:8]});
        2'd1: run({6'b001001, r[9:8], r[23:16]});
        2'd2: run({8'hE8, (r[23:22] == 2'h3) ? 2'h1 : r[23:22], r[21:16]});
        default: begin
          reg_wr(CAE_REG_BANK, 16'(r[13:8]));
          m_bank = r[13:8];
          reg_wr(CAE_REG_CTRL, 16'(r[16]));
          m_ext = r[16];
          run({8'h0B, r[31:24]});
        end
      endcase
    end
    close_out();
  end
endmodule
